/* File: hw/pdt_pkg.sv */
// shared constants, register map and carrier types of the operate-delay timer
package pdt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing: one processing cycle equals one setting step of the definite delay
    localparam int unsigned CLK_PERIOD_NS = 10;           // 100 MHz system clock
    localparam int unsigned STEP_TIME_NS = 5000000;       // 0.005 s per step
    localparam int unsigned TICK_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets on the apb bus
    localparam logic [11:0] OFS_CTRL = 12'h000;     // delay type, series, curve
    localparam logic [11:0] OFS_DEFINITE = 12'h004; // definite delay, 5 ms steps
    localparam logic [11:0] OFS_DIAL = 12'h008;     // time multiplier, 0.01 steps
    localparam logic [11:0] OFS_UA = 12'h00c;       // user constant a, 1e-4 steps
    localparam logic [11:0] OFS_UB = 12'h010;       // user constant b, 1e-4 steps
    localparam logic [11:0] OFS_UC = 12'h014;       // user constant c, 1e-4 steps
    localparam logic [11:0] OFS_PICKUP = 12'h018;   // pickup level
    localparam logic [11:0] OFS_STATUS = 12'h01c;   // live state, read only
    localparam logic [11:0] OFS_IRQ_STAT = 12'h020; // sticky events, write 1 clears
    localparam logic [11:0] OFS_IRQ_MASK = 12'h024; // event enables

    ////////////////////////////////////////////////////////////////////////////
    // reset values, in setting steps
    localparam logic [18:0] RST_DEFINITE = 19'h00008; // 0.040 s
    localparam logic [11:0] RST_DIAL = 12'h005;       // 0.05
    localparam logic [21:0] RST_UA = 22'h00035c;      // 0.0860
    localparam logic [15:0] RST_UB = 16'h073a;        // 0.1850
    localparam logic [21:0] RST_UC = 22'h0000c8;      // 0.0200
    localparam logic [15:0] RST_PICKUP = 16'h1000;    // plain default level

    ////////////////////////////////////////////////////////////////////////////
    // pickup release ratio and curve shaping
    localparam logic [6:0] HYST_PCT = 7'h61;          // release at 97 %
    localparam logic [6:0] PCT_FULL = 7'h64;          // 100 %
    localparam logic [21:0] SQ_EXP_MIN = 22'h004e20;  // exponent 2.0000 and up
    localparam logic [2:0] IEC_USER = 3'h4;           // iec user curve code
    localparam logic [2:0] IEEE_USER = 3'h7;          // ieee user curve code

    // settings that travel together into the timing logic
    typedef struct packed {
        logic inverse;          // 0 definite, 1 inverse
        logic ieee;             // 0 iec family, 1 ieee family
        logic [2:0] iec_curve;  // ni, ei, vi, lti, user
        logic [2:0] ieee_curve; // ansi ni, vi, ei, lti, ieee mi, vi, ei, user
        logic [18:0] definite;
        logic [11:0] dial;
        logic [21:0] ua;
        logic [15:0] ub;
        logic [21:0] uc;
        logic [15:0] pickup;
    } pdt_cfg_t;

    // event bits, same layout in irq status and mask
    typedef struct packed {
        logic blocked;
        logic trip;
        logic start;
    } pdt_evt_t;

endpackage : pdt_pkg

/* File: hw/pdt_curve.sv */
// inverse curve selection: per-cycle increment and trip target
`timescale 1ns/100ps
`default_nettype none
module pdt_curve (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // settings and measurement
    input wire pdt_pkg::pdt_cfg_t cfg,
    input wire logic [15:0] meas,
    // results
    output logic [31:0] incr,
    output logic [33:0] target
);

    ////////////////////////////////////////////////////////////////////////////
    // curve constant a (1e-4 units) and square flag per family and code
    function automatic logic [22:0] curve_a(input logic ieee, input logic [2:0] code);
        logic [22:0] r;
        r = 23'h0;
        if (!ieee) begin
            unique case (code)
                3'h0: r = {1'b0, 22'h000578};  // normally inverse
                3'h1: r = {1'b1, 22'h0c3500};  // extremely inverse
                3'h2: r = {1'b0, 22'h020f58};  // very inverse
                default: r = {1'b0, 22'h124f80}; // long-time inverse
            endcase
        end else begin
            unique case (code)
                3'h0: r = {1'b1, 22'h015d0c};  // ansi normally inverse
                3'h1: r = {1'b1, 22'h009934};  // ansi very inverse
                3'h2: r = {1'b1, 22'h00dc50};  // ansi extremely inverse
                3'h3: r = {1'b0, 22'h00db4c};  // ansi long-time inverse
                3'h4: r = {1'b0, 22'h000203};  // moderately inverse
                3'h5: r = {1'b1, 22'h02fe04};  // ieee very inverse
                default: r = {1'b1, 22'h044d90}; // ieee extremely inverse
            endcase
        end
        return r;
    endfunction : curve_a

    ////////////////////////////////////////////////////////////////////////////
    // selection; user curves take a from settings, exponent from b or c
    wire logic user_sel = cfg.ieee ? (cfg.ieee_curve == pdt_pkg::IEEE_USER)
                                   : (cfg.iec_curve == pdt_pkg::IEC_USER);
    wire logic [22:0] std_a = curve_a(cfg.ieee, cfg.ieee ? cfg.ieee_curve : cfg.iec_curve);
    wire logic [21:0] user_exp = cfg.ieee ? cfg.uc : {6'h00, cfg.ub};
    wire logic sq = user_sel ? (user_exp >= pdt_pkg::SQ_EXP_MIN) : std_a[22];
    wire logic [21:0] a_sel = user_sel ? cfg.ua : std_a[21:0];
    // excess above pickup; bigger excess, bigger increment, shorter delay
    wire logic [15:0] excess = (meas > cfg.pickup) ? meas - cfg.pickup : 16'h0000;
    wire logic [31:0] ex_sq = excess * excess;
    wire logic [31:0] next_incr = sq ? {8'h00, ex_sq[31:8]} : {16'h0000, excess};
    wire logic [33:0] next_target = cfg.dial * a_sel;

    // registered so the long product stays off the trip path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            incr <= 32'h0;
            target <= 34'h0;
        end else if (ce) begin
            incr <= next_incr;
            target <= next_target;
        end
    end

endmodule : pdt_curve
`default_nettype wire

/* File: hw/pdt_timer.sv */
// operate-delay timer top: apb registers, pickup, blocking and trip timing
//
// Function
// - instant mode trips together with start
// - definite mode trips after set delay
// - inverse delay shrinks as excess grows
// - definite delay floors inverse time, zero removes
// - delay type selects definite or inverse
// - definite delay in 5 ms steps, 40 ms
// - zero definite delay trips at once in definite mode
// - series picks iec or ieee, default iec
// - iec curves plus user a and b
// - ieee curves plus user a and c
// - inverse delay scaled by time multiplier
// - user constant a only for user curve
// - user constant b only for user curve
// - user constant c only ieee user curve
// - pickup releases at 97 percent of level
// - block sampled per cycle stops start, trip
`timescale 1ns/100ps
`default_nettype none
module pdt_timer #(
    parameter int unsigned TICK_CYCLES = pdt_pkg::TICK_CYCLES // processing cycle
) (
    // clock, reset, enable
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // measurement and blocking from the protection logic
    input wire logic [15:0] MEAS_VALUE,
    input wire logic BLOCK,
    // function outputs
    output logic START,
    output logic TRIP,
    output logic BLOCKED,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    wire logic setup = PSEL && !PENABLE;             // read data prepared here
    wire logic wr = PSEL && PENABLE && PWRITE;       // write takes effect here
    wire logic mapped = (PADDR <= pdt_pkg::OFS_IRQ_MASK) && (PADDR[1:0] == 2'h0);
    wire logic wr_ctrl = wr && (PADDR == pdt_pkg::OFS_CTRL);
    wire logic wr_def = wr && (PADDR == pdt_pkg::OFS_DEFINITE);
    wire logic wr_dial = wr && (PADDR == pdt_pkg::OFS_DIAL);
    wire logic wr_ua = wr && (PADDR == pdt_pkg::OFS_UA);
    wire logic wr_ub = wr && (PADDR == pdt_pkg::OFS_UB);
    wire logic wr_uc = wr && (PADDR == pdt_pkg::OFS_UC);
    wire logic wr_pick = wr && (PADDR == pdt_pkg::OFS_PICKUP);
    wire logic wr_istat = wr && (PADDR == pdt_pkg::OFS_IRQ_STAT);
    wire logic wr_imask = wr && (PADDR == pdt_pkg::OFS_IRQ_MASK);
    assign PREADY = 1'b1;                            // zero wait states
    assign PSLVERR = PSEL && PENABLE && !mapped;     // unmapped or misaligned

    ////////////////////////////////////////////////////////////////////////////
    // state declarations
    pdt_pkg::pdt_cfg_t sw_cfg;    // as written by software
    pdt_pkg::pdt_cfg_t work_cfg;  // copy used by the timing logic
    pdt_pkg::pdt_evt_t irq_stat;  // sticky events
    pdt_pkg::pdt_evt_t irq_mask;  // event enables
    logic [31:0] tick_cnt;        // processing cycle prescaler
    logic pickup;                 // comparator output with hysteresis
    logic blocked;                // block sampled at cycle start
    logic [18:0] elapsed;         // processing cycles since start
    logic [39:0] inv_acc;         // inverse integrator
    logic start_q;                // previous start, for the event edge
    logic trip_q;                 // previous trip, for the event edge
    logic blocked_q;              // previous blocked, for the event edge
    logic [31:0] incr;            // inverse increment per cycle
    logic [33:0] target;          // inverse integrator trip level
    typedef enum logic [1:0] {ST_IDLE, ST_TIMING, ST_TRIPPED} pdt_state_t;
    pdt_state_t state;
    pdt_state_t next_state;

    // processing cycle strobe
    wire logic tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////
    // software settings
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            sw_cfg <= '{inverse: 1'b0, ieee: 1'b0, iec_curve: 3'h0, ieee_curve: 3'h0,
                        definite: pdt_pkg::RST_DEFINITE, dial: pdt_pkg::RST_DIAL,
                        ua: pdt_pkg::RST_UA, ub: pdt_pkg::RST_UB, uc: pdt_pkg::RST_UC,
                        pickup: pdt_pkg::RST_PICKUP};
        end else if (CE) begin
            if (wr_ctrl) begin
                sw_cfg.inverse <= PWDATA[0];
                sw_cfg.ieee <= PWDATA[1];
                sw_cfg.iec_curve <= (PWDATA[4:2] > pdt_pkg::IEC_USER) ? 3'h0 : PWDATA[4:2];
                sw_cfg.ieee_curve <= PWDATA[7:5];
            end
            if (wr_def) sw_cfg.definite <= PWDATA[18:0];
            if (wr_dial) sw_cfg.dial <= PWDATA[11:0];
            if (wr_ua) sw_cfg.ua <= PWDATA[21:0];
            if (wr_ub) sw_cfg.ub <= PWDATA[15:0];
            if (wr_uc) sw_cfg.uc <= PWDATA[21:0];
            if (wr_pick) sw_cfg.pickup <= PWDATA[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux, registered in the setup phase
    wire logic [31:0] ctrl_rd = {24'h0, sw_cfg.ieee_curve, sw_cfg.iec_curve,
                                 sw_cfg.ieee, sw_cfg.inverse};
    wire logic [31:0] status_rd = {28'h0, TRIP, START, blocked, pickup};
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0;
        unique case (PADDR)
            pdt_pkg::OFS_CTRL: next_rdata = ctrl_rd;
            pdt_pkg::OFS_DEFINITE: next_rdata = {13'h0, sw_cfg.definite};
            pdt_pkg::OFS_DIAL: next_rdata = {20'h0, sw_cfg.dial};
            pdt_pkg::OFS_UA: next_rdata = {10'h0, sw_cfg.ua};
            pdt_pkg::OFS_UB: next_rdata = {16'h0, sw_cfg.ub};
            pdt_pkg::OFS_UC: next_rdata = {10'h0, sw_cfg.uc};
            pdt_pkg::OFS_PICKUP: next_rdata = {16'h0, sw_cfg.pickup};
            pdt_pkg::OFS_STATUS: next_rdata = status_rd;
            pdt_pkg::OFS_IRQ_STAT: next_rdata = {29'h0, irq_stat};
            pdt_pkg::OFS_IRQ_MASK: next_rdata = {29'h0, irq_mask};
            default: next_rdata = 32'h0; // unmapped reads zero
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) PRDATA <= 32'h0;
        else if (CE && setup) PRDATA <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler and per-cycle sampling of settings, measurement and block
    // settings enter only at a cycle boundary, so a mid-cycle write never
    // meets a half-updated comparison
    wire logic [22:0] meas_pct = MEAS_VALUE * pdt_pkg::PCT_FULL;
    wire logic [22:0] drop_pct = work_cfg.pickup * pdt_pkg::HYST_PCT;
    wire logic next_pickup = pickup ? (meas_pct >= drop_pct)
                                    : (MEAS_VALUE >= work_cfg.pickup);
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            tick_cnt <= 32'h0;
            work_cfg <= '0;
            pickup <= 1'b0;
            blocked <= 1'b0;
        end else if (CE) begin
            tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
            if (tick) begin
                work_cfg <= sw_cfg;
                pickup <= next_pickup;
                blocked <= BLOCK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // inverse characteristic
    pdt_curve u_curve (
        .clk(CLOCK),
        .rst(RST),
        .ce(CE),
        .cfg(work_cfg),
        .meas(MEAS_VALUE),
        .incr(incr),
        .target(target)
    );

    ////////////////////////////////////////////////////////////////////////////
    // timing decisions
    wire logic started = pickup && !blocked;
    wire logic instant = !work_cfg.inverse && (work_cfg.definite == 19'h0);
    wire logic floor_ok = (elapsed >= work_cfg.definite);
    wire logic inv_done = ({6'h00, target} <= inv_acc);
    wire logic due = work_cfg.inverse ? (inv_done && floor_ok) : floor_ok;
    wire logic [18:0] next_elapsed = (elapsed == 19'h7ffff) ? elapsed : elapsed + 19'h1;
    wire logic [39:0] next_acc = inv_acc + {8'h00, incr};

    // state sequence, advanced once per processing cycle
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (started) next_state = ST_TIMING;
            ST_TIMING: begin
                if (!started) next_state = ST_IDLE;
                else if (due) next_state = ST_TRIPPED;
            end
            ST_TRIPPED: if (!started) next_state = ST_IDLE;
        endcase
    end

    // integrate only while started; reset on drop or block
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state <= ST_IDLE;
            elapsed <= 19'h0;
            inv_acc <= 40'h0;
        end else if (CE && tick) begin
            state <= next_state;
            elapsed <= (next_state == ST_IDLE) ? 19'h0 : next_elapsed;
            inv_acc <= (next_state == ST_IDLE) ? 40'h0 : next_acc;
        end
    end

    // trip stands with start; instant mode needs no timing
    assign START = started;
    assign TRIP = started && (instant || state == ST_TRIPPED);
    assign BLOCKED = pickup && blocked;

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: set wins over a simultaneous write-one clear
    wire pdt_pkg::pdt_evt_t evt = '{blocked: BLOCKED && !blocked_q, trip: TRIP && !trip_q,
                                    start: START && !start_q};
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            irq_stat <= '0;
            irq_mask <= '0;
            start_q <= 1'b0;
            trip_q <= 1'b0;
            blocked_q <= 1'b0;
        end else if (CE) begin
            start_q <= START;
            trip_q <= TRIP;
            blocked_q <= BLOCKED;
            irq_stat <= evt | (irq_stat & ~(wr_istat ? PWDATA[2:0] : 3'h0));
            if (wr_imask) irq_mask <= PWDATA[2:0];
        end
    end
    assign IRQ = |(irq_stat & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    // plain wire of the same condition, so it can be looked back on with $past
    wire logic tick_run = CE && tick && started;

    sequence tick_started_s;
        tick_run;
    endsequence

    instant_trip_a: assert property (START && instant |-> TRIP)
        else $error("instant mode start without trip");
    trip_start_a: assert property (TRIP |-> START)
        else $error("trip without start");
    block_stop_a: assert property (blocked |-> !START && !TRIP)
        else $error("start or trip while blocked");
    dt_floor_a: assert property (TRIP && !instant |-> elapsed >= work_cfg.definite)
        else $error("trip before definite delay");
    inv_level_a: assert property (TRIP && work_cfg.inverse |-> inv_acc >= {6'h00, target})
        else $error("inverse trip below integrator level");
    hyst_hold_a: assert property (CE && tick && pickup && meas_pct >= drop_pct |=> pickup)
        else $error("pickup dropped above release level");
    cfg_hold_a: assert property (!(CE && tick) |=> $stable(work_cfg))
        else $error("settings changed inside a cycle");
    trip_edge_a: assert property ($rose(state == ST_TRIPPED) |-> $past(tick_run))
        else $error("timer tripped off a cycle boundary");
    elapsed_step_a: assert property (tick_started_s ##1 state != ST_IDLE
            |-> elapsed == $past(next_elapsed))
        else $error("elapsed count did not advance");

endmodule : pdt_timer
`default_nettype wire

/* File: bench/pdt_far_end.sv */
// far-end model: measurement source and blocking matrix feeding the timer
`timescale 1ns/100ps
`default_nettype none
module pdt_far_end (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // commands from the bench
    input wire logic [15:0] level,
    input wire logic blk,
    // lines into the timer
    output logic [15:0] meas_value,
    output logic block
);
    ////////////////////////////////////////////////////////////////////////////
    // values move just after a clock edge, as same-clock protection logic would
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meas_value <= 16'h0000; // no measurement while in reset
            block <= 1'b0;          // matrix idle
        end else begin
            meas_value <= level;
            block <= blk;
        end
    end
endmodule : pdt_far_end
`default_nettype wire

/* File: bench/tb_protection_operate_delay_timer.sv */
// self-checking bench of the operate-delay timer, driven over apb
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_protection_operate_delay_timer;
    localparam int unsigned TICK = 8; // short processing cycle keeps the run brief
    // clock, reset and apb
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // far end and function outputs
    logic [15:0] level = 16'h0000;
    logic blk = 1'b0;
    logic [15:0] meas_value;
    logic block;
    logic start;
    logic trip;
    logic blocked;
    logic irq;
    // bookkeeping
    int errors = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic err;
    int t_a;
    int t_b;
    int t_c;
    logic [11:0] ofs [7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018};
    logic [31:0] dflt [7] = '{32'h0, 32'h8, 32'h5, 32'h35c, 32'h73a, 32'hc8, 32'h1000};

    pdt_timer #(.TICK_CYCLES(TICK)) pdt_timer_i (.CLOCK(clock), .RST(rst), .CE(ce),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MEAS_VALUE(meas_value),
        .BLOCK(block), .START(start), .TRIP(trip), .BLOCKED(blocked), .IRQ(irq));
    pdt_far_end pdt_far_end_i (.clk(clock), .rst(rst), .level(level), .blk(blk),
        .meas_value(meas_value), .block(block));

    always #5 clock = ~clock; // 100 MHz

    ////////////////////////////////////////////////////////////////////////////
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // bounded waits; samples are taken right after the edge, before it updates
    task automatic wait_start();
        for (int n = 0; n < 6000 && start !== 1'b1; n++) @(posedge clock);
    endtask : wait_start
    task automatic time_trip(output int cyc);
        wait_start();
        for (cyc = 0; cyc < 6000 && trip !== 1'b1; cyc++) @(posedge clock);
    endtask : time_trip
    // drop the measurement and let the pickup fall away
    task automatic idle();
        level <= 16'h0000;
        repeat (3 * TICK) @(posedge clock);
    endtask : idle

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        // defaults after reset, then an unmapped and a misaligned access
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            `CHK(rd, dflt[i])
        end
        apb(1'b0, 12'h028, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, 12'h006, 32'h3);
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, 32'h8)
        // definite: delay difference follows the setting, not the magnitude or series
        apb(1'b1, 12'h018, 32'h100);
        apb(1'b1, 12'h004, 32'h2);
        level <= 16'h0200;
        time_trip(t_a);
        idle();
        apb(1'b1, 12'h000, 32'he2);
        apb(1'b1, 12'h004, 32'h4);
        level <= 16'h7000;
        time_trip(t_b);
        `CHK(t_b - t_a, 2 * TICK)
        idle();
        // block kills a running start before the long delay expires
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h14);
        level <= 16'h0200;
        wait_start();
        blk <= 1'b1;
        repeat (2 * TICK) @(posedge clock);
        `CHK({start, trip, blocked}, 3'b001)
        blk <= 1'b0;
        idle();
        // instant trip together with start, interrupt raised, masked and cleared
        apb(1'b1, 12'h020, 32'h7);
        apb(1'b1, 12'h024, 32'h2);
        apb(1'b1, 12'h004, 32'h0);
        level <= 16'h0200;
        wait_start();
        `CHK(trip, 1'b1)
        repeat (2) @(posedge clock);
        `CHK(irq, 1'b1)
        apb(1'b0, 12'h020, 32'h0);
        `CHK(rd, 32'h3)
        apb(1'b1, 12'h020, 32'h2);
        @(posedge clock);
        `CHK(irq, 1'b0)
        idle();
        // pickup at the level, release only below 97 percent of it
        apb(1'b1, 12'h018, 32'h64);
        level <= 16'h0063;
        repeat (3 * TICK) @(posedge clock);
        `CHK(start, 1'b0)
        level <= 16'h0064;
        repeat (3 * TICK) @(posedge clock);
        `CHK(start, 1'b1)
        level <= 16'h0061;
        repeat (3 * TICK) @(posedge clock);
        `CHK(start, 1'b1)
        level <= 16'h0060;
        repeat (3 * TICK) @(posedge clock);
        `CHK(start, 1'b0)
        // enable low freezes the timer: no pickup until it runs again
        ce <= 1'b0;
        level <= 16'h0064;
        repeat (3 * TICK) @(posedge clock);
        `CHK(start, 1'b0)
        ce <= 1'b1;
        repeat (3 * TICK) @(posedge clock);
        `CHK(start, 1'b1)
        level <= 16'h0060;
        repeat (3 * TICK) @(posedge clock);
        `CHK(start, 1'b0)
        // inverse user curve: excess, multiplier and definite floor
        apb(1'b1, 12'h018, 32'h100);
        apb(1'b1, 12'h000, 32'h11);
        apb(1'b1, 12'h008, 32'h64);
        level <= 16'h0300;
        time_trip(t_a);
        idle();
        level <= 16'h0500;
        time_trip(t_b);
        `CHK(t_b < t_a, 1'b1)
        idle();
        apb(1'b1, 12'h008, 32'hc8);
        level <= 16'h0500;
        time_trip(t_c);
        `CHK(t_c > t_b, 1'b1)
        idle();
        apb(1'b1, 12'h008, 32'h64);
        apb(1'b1, 12'h004, 32'h100);
        level <= 16'h0500;
        time_trip(t_c);
        `CHK(t_c >= 255 * TICK && t_c < 6000, 1'b1)
        idle();
        // every curve of both families trips on a heavy excess
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h008, 32'h1);
        for (int c = 0; c < 13; c++) begin
            t_a = (c < 5) ? (1 | (c << 2)) : (3 | ((c - 5) << 5));
            apb(1'b1, 12'h000, t_a);
            apb(1'b0, 12'h000, 32'h0);
            `CHK(rd, t_a)
            level <= 16'h8000;
            time_trip(t_b);
            `CHK(trip, 1'b1)
            idle();
        end
        wrap_up();
    end

    // watchdog: well past the expected length of the run
    initial begin
        #900000;
        errors++;
        wrap_up();
    end
endmodule : tb_protection_operate_delay_timer
`default_nettype wire
